// *** verilog/relay_mode_ctrl.sv ***
`timescale 1ns/100ps
module relay_mode_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic limp_home_in,
  input wire logic reset_in_n,
  input wire logic direct_input_1,
  input wire logic direct_input_2,
  input wire logic direct_input_3,
  input wire logic direct_input_4,
  output logic channel_out_1,
  output logic channel_out_2,
  output logic channel_out_3,
  output logic channel_out_4,
  output logic channel_out_5,
  output logic channel_out_6,
  output logic channel_out_7,
  output logic channel_out_8,
  output logic irq
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [5:0] pins_s;
  logic limp_s;
  logic rst_s;
  logic [3:0] in_s;

  pin_sync #(.WIDTH(6)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({reset_in_n, limp_home_in, direct_input_4, direct_input_3, direct_input_2, direct_input_1}),
    .sync_out(pins_s)
  );

  // Open pins are held low by the pad pull-downs, so a floating input
  // reaches this logic as a zero and its channels stay off.
  assign in_s = pins_s[3:0];
  assign limp_s = pins_s[4];
  assign rst_s = pins_s[5];

  // ----------------------------------------------------------------
  // Operating mode
  // ----------------------------------------------------------------
  relay_ctrl_pkg::mode_t mode_q;
  relay_ctrl_pkg::mode_t mode_d;

  always_comb
  begin
    if (limp_s)
      mode_d = relay_ctrl_pkg::MODE_LIMP;
    else if (!rst_s)
      mode_d = relay_ctrl_pkg::MODE_STANDBY;
    else
      mode_d = relay_ctrl_pkg::MODE_NORMAL;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_q <= relay_ctrl_pkg::MODE_STANDBY;
    else
      mode_q <= mode_d;
  end

  logic limp_exit;
  logic clear_regs;
  assign limp_exit = (mode_q == relay_ctrl_pkg::MODE_LIMP) && !limp_s;
  // The exit cycle clears as well, so no control register written before limp home survives it.
  assign clear_regs = limp_s || !rst_s || (mode_q == relay_ctrl_pkg::MODE_LIMP);

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic access;
  logic done;
  logic wr_en;
  logic [5:0] idx;
  logic mapped;
  assign access = psel && penable;
  assign done = access && pready;
  assign idx = paddr[7:2];
  assign mapped = (idx <= relay_ctrl_pkg::IRQ_MASK_IDX);
  // Control register writes land only in normal mode; limp home and reset discard them.
  assign wr_en = done && pwrite && mapped && !clear_regs && (mode_q == relay_ctrl_pkg::MODE_NORMAL);

  logic [7:0] onoff_q;
  logic [7:0] inmode_q;
  logic [15:0] select_q;
  logic [2:0] irq_stat_q;
  logic [2:0] irq_mask_q;
  logic post_flag_q;
  logic [7:0] ch_q;

  // One wait state: the answer is registered from the first access cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= access && !pready;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (access && !pready)
    begin
      pslverr <= !mapped;
      prdata <= 32'h0000_0000;
      if (!pwrite)
      begin
        unique case (idx)
          relay_ctrl_pkg::ONOFF_IDX: prdata <= {24'h00_0000, onoff_q};
          relay_ctrl_pkg::INMODE_IDX: prdata <= {24'h00_0000, inmode_q};
          relay_ctrl_pkg::SELECT_IDX: prdata <= {16'h0000, select_q};
          relay_ctrl_pkg::STATUS_IDX: prdata <= {20'h0_0000, ch_q, 1'b0, post_flag_q, mode_q};
          relay_ctrl_pkg::IRQ_STAT_IDX: prdata <= {29'h0000_0000, irq_stat_q};
          relay_ctrl_pkg::IRQ_MASK_IDX: prdata <= {29'h0000_0000, irq_mask_q};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      onoff_q <= relay_ctrl_pkg::ONOFF_RST;
      inmode_q <= relay_ctrl_pkg::INMODE_RST;
      select_q <= relay_ctrl_pkg::SELECT_RST;
    end
    else if (clear_regs)
    begin
      onoff_q <= relay_ctrl_pkg::ONOFF_RST;
      inmode_q <= relay_ctrl_pkg::INMODE_RST;
      select_q <= relay_ctrl_pkg::SELECT_RST;
    end
    else if (wr_en)
    begin
      if (idx == relay_ctrl_pkg::ONOFF_IDX)
        onoff_q <= pwdata[7:0];
      if (idx == relay_ctrl_pkg::INMODE_IDX)
        inmode_q <= pwdata[7:0];
      if (idx == relay_ctrl_pkg::SELECT_IDX)
        select_q <= pwdata[15:0];
    end
  end

  // The flag reads set on the first transfer after limp home, then drops;
  // a fresh exit in the clearing cycle wins.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      post_flag_q <= 1'b0;
    else if (limp_exit)
      post_flag_q <= 1'b1;
    else if (done)
      post_flag_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [2:0] ev;
  always_comb
  begin
    ev = 3'h0;
    ev[relay_ctrl_pkg::EV_LIMP_ENTER] = limp_s && (mode_q != relay_ctrl_pkg::MODE_LIMP);
    ev[relay_ctrl_pkg::EV_LIMP_EXIT] = limp_exit;
    ev[relay_ctrl_pkg::EV_STANDBY] = (mode_d == relay_ctrl_pkg::MODE_STANDBY) &&
                                     (mode_q != relay_ctrl_pkg::MODE_STANDBY);
  end

  // Status and mask live outside the clearable set, so mode events stay visible.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat_q <= relay_ctrl_pkg::IRQ_RST;
      irq_mask_q <= relay_ctrl_pkg::IRQ_RST;
    end
    else
    begin
      if (done && pwrite && idx == relay_ctrl_pkg::IRQ_STAT_IDX)
        irq_stat_q <= (irq_stat_q & ~pwdata[2:0]) | ev;
      else
        irq_stat_q <= irq_stat_q | ev;
      if (done && pwrite && idx == relay_ctrl_pkg::IRQ_MASK_IDX)
        irq_mask_q <= pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(irq_stat_q & irq_mask_q);
  end

  // ----------------------------------------------------------------
  // Channel drive
  // ----------------------------------------------------------------
  logic [7:0] cmd;
  genvar g;
  generate
    for (g = 0; g < relay_ctrl_pkg::NUM_CH; g++)
    begin : g_ch
      channel_select u_ch (
        .on_bit(onoff_q[g]),
        .input_mode(inmode_q[g]),
        .input_select_field(select_q[2*g+1:2*g]),
        .direct_in(in_s),
        .cmd(cmd[g])
      );
    end
  endgenerate

  logic [7:0] ch_d;
  always_comb
  begin
    unique case (mode_q)
      relay_ctrl_pkg::MODE_LIMP: ch_d = {4'h0, in_s};
      relay_ctrl_pkg::MODE_NORMAL: ch_d = cmd;
      relay_ctrl_pkg::MODE_STANDBY: ch_d = 8'h00;
      default: ch_d = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ch_q <= 8'h00;
    else
      ch_q <= ch_d;
  end

  assign {channel_out_8, channel_out_7, channel_out_6, channel_out_5,
          channel_out_4, channel_out_3, channel_out_2, channel_out_1} = ch_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_in_limp;
    mode_q == relay_ctrl_pkg::MODE_LIMP;
  endsequence

  sequence s_limp_exit;
    (mode_q == relay_ctrl_pkg::MODE_LIMP) ##1 (mode_q != relay_ctrl_pkg::MODE_LIMP);
  endsequence

  a_limp_routing: assert property (@(posedge pclk) disable iff (!presetn)
    s_in_limp |=> ch_q[3:0] == $past(in_s))
    else $error("limp home routing of channels one to four is wrong");

  a_limp_high_off: assert property (@(posedge pclk) disable iff (!presetn)
    s_in_limp |=> ch_q[7:4] == 4'h0)
    else $error("channels five to eight not off in limp home");

  a_limp_priority: assert property (@(posedge pclk) disable iff (!presetn)
    limp_s |=> mode_q == relay_ctrl_pkg::MODE_LIMP)
    else $error("limp home did not override reset or standby");

  a_limp_clears: assert property (@(posedge pclk) disable iff (!presetn)
    limp_s |=> (onoff_q == 8'h00) && (inmode_q == 8'h00) && (select_q == 16'h0000))
    else $error("registers not cleared in limp home");

  // A write that lands while limp home lasts would show in the second limp cycle.
  a_limp_ignores: assert property (@(posedge pclk) disable iff (!presetn)
    s_in_limp ##1 s_in_limp |-> (onoff_q == 8'h00) && (inmode_q == 8'h00) && !wr_en)
    else $error("serial write took effect in limp home");

  a_exit_flag: assert property (@(posedge pclk) disable iff (!presetn)
    s_limp_exit |-> post_flag_q && onoff_q == 8'h00)
    else $error("post reset flag not raised after limp home");

  a_exit_dest: assert property (@(posedge pclk) disable iff (!presetn)
    (s_in_limp and !limp_s) |=> mode_q == ($past(rst_s) ? relay_ctrl_pkg::MODE_NORMAL : relay_ctrl_pkg::MODE_STANDBY))
    else $error("wrong mode after limp home");

  a_reset_defaults: assert property (@(posedge pclk) disable iff (!presetn)
    (!rst_s && !limp_s) |=> (onoff_q == 8'h00) ##1 (ch_q == 8'h00))
    else $error("reset pin did not force defaults and channels off");

  a_serial_ctl: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_q == relay_ctrl_pkg::MODE_NORMAL && !inmode_q[0]) |=> ch_q[0] == $past(onoff_q[0]))
    else $error("channel one does not follow its on bit");

  a_input_ctl: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_q == relay_ctrl_pkg::MODE_NORMAL && inmode_q[1]) |=> ch_q[1] == $past(in_s[select_q[3:2]]))
    else $error("channel two does not follow its selected input");

endmodule // relay_mode_ctrl

// *** verilog/relay_ctrl_pkg.sv ***
// Contract
// - Power-on reset loads register defaults, enters standby, all channels off.
// - Reset pin low forces register defaults and minimum activity. Interrupt status and mask keep their values here.
// - High limp-home input enters limp home and clears serial registers. Interrupt status and mask are not cleared here.
// - In limp home, direct inputs one to four drive channels one to four.
// - In limp home, channels five to eight stay off.
// - In limp home, serial writes are ignored; fixed routing is used. Interrupt status and mask writes still land here.
// - Limp home beats reset pin; limp home during standby wakes the device.
// - Leaving limp home resets registers; standby if reset low, else idle. Interrupt status and mask are not reset here.
// - First serial transfer after limp home returns the post-reset flag set.
// - Per-channel input select field chooses which direct input controls the channel.
// - Unconnected input pin reads low, so its channels switch off.
// - In input mode, selected input high means on, low means off.
// - Under serial control, the channel follows its serial on/off bit.
// - Reset pin and chip select are active low. Here psel is active high.
// - Unconnected limp-home input reads low, keeping device out of limp home.
package relay_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [5:0] ONOFF_IDX = 6'h00;
  localparam logic [5:0] INMODE_IDX = 6'h01;
  localparam logic [5:0] SELECT_IDX = 6'h02;
  localparam logic [5:0] STATUS_IDX = 6'h03;
  localparam logic [5:0] IRQ_STAT_IDX = 6'h04;
  localparam logic [5:0] IRQ_MASK_IDX = 6'h05;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int NUM_CH = 8;
  localparam int NUM_IN = 4;
  localparam int NUM_EV = 3;
  localparam int EV_LIMP_ENTER = 0;
  localparam int EV_LIMP_EXIT = 1;
  localparam int EV_STANDBY = 2;
  localparam int ST_FLAG_BIT = 2;
  localparam int ST_CH_LSB = 4;
  localparam logic [7:0] ONOFF_RST = 8'h00;
  localparam logic [7:0] INMODE_RST = 8'h00;
  localparam logic [15:0] SELECT_RST = 16'h0000;
  localparam logic [2:0] IRQ_RST = 3'h0;

  typedef enum logic [1:0] {
    MODE_STANDBY = 2'b00,
    MODE_NORMAL = 2'b01,
    MODE_LIMP = 2'b10
  } mode_t;

endpackage

// *** verilog/pin_sync.sv ***
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // Only the second stage is visible outside; the first may be metastable.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // pin_sync

// *** verilog/channel_select.sv ***
`timescale 1ns/100ps
module channel_select (
  input wire logic on_bit,
  input wire logic input_mode,
  input wire logic [1:0] input_select_field,
  input wire logic [3:0] direct_in,
  output logic cmd
);

  always_comb
  begin
    if (input_mode)
      cmd = direct_in[input_select_field];
    else
      cmd = on_bit;
  end

endmodule // channel_select

// *** sim/mcu_pin_model.sv ***
`timescale 1ns/100ps
module mcu_pin_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic limp_req,
  input wire logic reset_req_n,
  input wire logic [3:0] din_req,
  output logic limp_home_in,
  output logic reset_in_n,
  output logic [3:0] direct_in
);
  // --------------------------------------------------------------
  // Pin drivers
  // --------------------------------------------------------------
  // An open pin is modelled at its pull-down level, so open reads low.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      limp_home_in <= 1'b0;
      reset_in_n <= 1'b0;
      direct_in <= 4'h0;
    end
    else
    begin
      limp_home_in <= limp_req;
      reset_in_n <= reset_req_n;
      direct_in <= din_req;
    end
  end
endmodule // mcu_pin_model

// *** sim/relay_mode_ctrl_tb.sv ***
`timescale 1ns/100ps
module relay_mode_ctrl_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
  logic lh_req, rn_req, lh, rn;
  logic [7:0] paddr, on_v, md_v;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] din_req, din;
  logic [15:0] sel_v;
  wire [7:0] ch;
  int miscompares, check_count, i;
  int seed = 32'h22679774;

  mcu_pin_model mcu_pin_model_inst (.pclk(pclk), .presetn(presetn), .limp_req(lh_req),
    .reset_req_n(rn_req), .din_req(din_req), .limp_home_in(lh), .reset_in_n(rn), .direct_in(din));

  relay_mode_ctrl relay_mode_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .limp_home_in(lh), .reset_in_n(rn),
    .direct_input_1(din[0]), .direct_input_2(din[1]), .direct_input_3(din[2]),
    .direct_input_4(din[3]), .channel_out_1(ch[0]), .channel_out_2(ch[1]),
    .channel_out_3(ch[2]), .channel_out_4(ch[3]), .channel_out_5(ch[4]),
    .channel_out_6(ch[5]), .channel_out_7(ch[6]), .channel_out_8(ch[7]), .irq(irq));

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function automatic logic [7:0] exp_ch(logic [7:0] on, logic [7:0] md, logic [15:0] sel,
    logic [3:0] d);
    logic [7:0] r;
    for (int n = 0; n < 8; n++)
    begin
      r[n] = md[n] ? d[sel[2*n+:2]] : on[n];
    end
    return r;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // The master holds the request until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      miscompares++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd_chk(input logic [5:0] idx, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, idx, 32'h0);
    chk(rd & m, e, "register read");
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic done_t(input string s);
    $display("test %s done", s);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // --------------------------------------------------------------
  // Clock, watchdog and tests
  // --------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  initial
  begin
    #100000;
    miscompares++;
    report_and_stop();
  end

  initial
  begin
    {presetn, psel, penable, pwrite, lh_req} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rn_req = 1'b1;
    din_req = 4'h0;
    wt(4);
    presetn <= 1'b1;
    wt(8);
    chk(ch, 8'h00, "channels after reset");
    rd_chk(relay_ctrl_pkg::ONOFF_IDX, 32'hffffffff, 32'h0);
    rd_chk(relay_ctrl_pkg::SELECT_IDX, 32'hffffffff, 32'h0);
    chk(er, 1'b0, "mapped read error");
    apb(1'b1, relay_ctrl_pkg::IRQ_MASK_IDX, 32'h7);
    apb(1'b1, relay_ctrl_pkg::IRQ_STAT_IDX, 32'h7);
    done_t("defaults");
    for (i = 0; i < 10; i++)
    begin
      on_v = (i == 0) ? 8'hff : 8'($random(seed));
      md_v = (i < 3) ? 8'h00 : (i == 3) ? 8'hff : 8'($random(seed));
      sel_v = 16'($random(seed));
      din_req <= (i == 3) ? 4'h0 : 4'($random(seed));
      apb(1'b1, relay_ctrl_pkg::ONOFF_IDX, {24'h0, on_v});
      apb(1'b1, relay_ctrl_pkg::INMODE_IDX, {24'h0, md_v});
      apb(1'b1, relay_ctrl_pkg::SELECT_IDX, {16'h0, sel_v});
      wt(8);
      chk(ch, exp_ch(on_v, md_v, sel_v, din_req), "channel routing");
    end
    done_t("routing");
    lh_req <= 1'b1;
    din_req <= 4'($random(seed));
    wt(8);
    rd_chk(relay_ctrl_pkg::STATUS_IDX, 32'h3, 32'h2);
    rd_chk(relay_ctrl_pkg::INMODE_IDX, 32'hffffffff, 32'h0);
    chk(ch, {4'h0, din_req}, "limp channels");
    apb(1'b1, relay_ctrl_pkg::ONOFF_IDX, 32'hff);
    apb(1'b1, relay_ctrl_pkg::INMODE_IDX, 32'hff);
    rd_chk(relay_ctrl_pkg::ONOFF_IDX, 32'hffffffff, 32'h0);
    din_req <= ~din_req;
    wt(8);
    chk(ch, {4'h0, din_req}, "limp fixed routing");
    rn_req <= 1'b0;
    wt(8);
    rd_chk(relay_ctrl_pkg::STATUS_IDX, 32'h3, 32'h2);
    lh_req <= 1'b0;
    wt(8);
    rd_chk(relay_ctrl_pkg::STATUS_IDX, 32'h3, 32'h0);
    chk(ch, 8'h00, "standby channels");
    lh_req <= 1'b1;
    wt(8);
    rd_chk(relay_ctrl_pkg::STATUS_IDX, 32'h3, 32'h2);
    rn_req <= 1'b1;
    lh_req <= 1'b0;
    wt(8);
    rd_chk(relay_ctrl_pkg::STATUS_IDX, 32'h7, 32'h5);
    rd_chk(relay_ctrl_pkg::STATUS_IDX, 32'h7, 32'h1);
    rd_chk(relay_ctrl_pkg::SELECT_IDX, 32'hffffffff, 32'h0);
    chk(ch, 8'h00, "idle channels");
    done_t("limp home");
    apb(1'b1, relay_ctrl_pkg::ONOFF_IDX, 32'hff);
    rn_req <= 1'b0;
    wt(8);
    chk(ch, 8'h00, "reset pin channels");
    rd_chk(relay_ctrl_pkg::ONOFF_IDX, 32'hffffffff, 32'h0);
    rn_req <= 1'b1;
    wt(8);
    done_t("reset pin");
    rd_chk(relay_ctrl_pkg::IRQ_STAT_IDX, 32'hffffffff, 32'h7);
    chk(irq, 1'b1, "irq raised");
    apb(1'b1, relay_ctrl_pkg::IRQ_MASK_IDX, 32'h0);
    wt(2);
    chk(irq, 1'b0, "irq masked");
    apb(1'b1, relay_ctrl_pkg::IRQ_MASK_IDX, 32'h7);
    apb(1'b1, relay_ctrl_pkg::IRQ_STAT_IDX, 32'h1);
    rd_chk(relay_ctrl_pkg::IRQ_STAT_IDX, 32'hffffffff, 32'h6);
    apb(1'b1, relay_ctrl_pkg::IRQ_STAT_IDX, 32'h6);
    wt(2);
    chk(irq, 1'b0, "irq cleared");
    apb(1'b0, 6'h06, 32'h0);
    chk(rd, 32'h0, "unmapped read data");
    chk(er, 1'b1, "unmapped read error");
    done_t("irq and bus");
    apb(1'b1, relay_ctrl_pkg::ONOFF_IDX, 32'hff);
    apb(1'b1, relay_ctrl_pkg::IRQ_MASK_IDX, 32'h5);
    wt(2);
    chk(ch, 8'hff, "channels before second reset");
    presetn <= 1'b0;
    wt(4);
    chk(ch, 8'h00, "channels in power-on reset");
    presetn <= 1'b1;
    wt(8);
    chk(ch, 8'h00, "channels after second reset");
    rd_chk(relay_ctrl_pkg::ONOFF_IDX, 32'hffffffff, 32'h0);
    rd_chk(relay_ctrl_pkg::IRQ_MASK_IDX, 32'hffffffff, 32'h0);
    done_t("power-on reset");
    report_and_stop();
  end
endmodule // relay_mode_ctrl_tb
